// ==== src/wave_cap_pkg.sv ====
// Constants shared by the probe waveform capture block
package wave_cap_pkg;
   // -------------------------------------------------
   // Timing figures
   // -------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;                  // 25 MHz system clock
   localparam int SAMPLE_NS     = 20;                  // Spacing of stored samples
   localparam int WINDOW_NS     = 640;                 // History kept before stop
   localparam int SMP_PER_CLK   = CLK_PERIOD_NS / SAMPLE_NS;
   localparam int STORE_DEPTH   = WINDOW_NS / SAMPLE_NS;
   localparam int DLY_STEP_PS   = 3000;                // Nominal delay line step
   localparam int DLY_MAX_STEPS = 12;                  // Longest delay setting
   localparam int STOP_CNT_W    = 16;                  // Stop counter width

   // -------------------------------------------------
   // Sample encoding and reset values
   // -------------------------------------------------
   localparam logic [1:0] SMP_LOW   = 2'h0;
   localparam logic [1:0] SMP_HIGH  = 2'h1;
   localparam logic [1:0] SMP_FLOAT = 2'h2;
   localparam logic [1:0] SMP_RST   = SMP_FLOAT;
   localparam logic [3:0] DLY_RST   = 4'h0;

   typedef enum logic [1:0] {ST_IDLE, ST_CAPTURE, ST_FROZEN, ST_DUMP} cap_state_e;

   // Comparator pair to three-state code: both high is high, none is low
   function automatic logic [1:0] classify(input logic above_hi, input logic above_lo);
      if (above_hi && above_lo) begin
         classify = SMP_HIGH;
      end else if (!above_hi && !above_lo) begin
         classify = SMP_LOW;
      end else begin
         classify = SMP_FLOAT;
      end
   endfunction
endpackage

// ==== src/skid_buf2.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module skid_buf2 #(
   parameter int W = 2
) (
   input  wire logic         clk_i,       // System clock
   input  wire logic         reset_i,     // Async reset, high
   input  wire logic         in_valid_i,  // Word offered
   input  wire logic [W-1:0] in_data_i,   // Word
   output logic              in_ready_o,  // Room for a word
   output logic              out_valid_o, // Head word valid
   output logic [W-1:0]      out_data_o,  // Head word
   input  wire logic         out_ready_i  // Receiver takes head
);
   typedef struct packed {
      logic [W-1:0] head;
      logic         head_v;
      logic [W-1:0] skid;
      logic         skid_v;
   } buf_s;

   buf_s st_ff;
   buf_s nxt_st;

   // -------------------------------------------------
   // Next state: pop first, then fill head or skid
   // -------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (st_ff.head_v && out_ready_i) begin
         if (st_ff.skid_v) begin
            nxt_st.head   = st_ff.skid;
            nxt_st.skid_v = 1'b0;
         end else begin
            nxt_st.head_v = 1'b0;
         end
      end
      // Ready comes from skid_v so a stall never drops a word
      if (in_valid_i && !st_ff.skid_v) begin
         if (!nxt_st.head_v) begin
            nxt_st.head   = in_data_i;
            nxt_st.head_v = 1'b1;
         end else begin
            nxt_st.skid   = in_data_i;
            nxt_st.skid_v = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign in_ready_o  = !st_ff.skid_v;
   assign out_valid_o = st_ff.head_v;
   assign out_data_o  = st_ff.head;
endmodule

// ==== src/probe_wave_capture.sv ====
// Probe waveform capture: rolling three-state store frozen by stop
`timescale 1ns/1ps
module probe_wave_capture
   import wave_cap_pkg::*;
#(
   parameter int DEPTH = wave_cap_pkg::STORE_DEPTH,
   parameter int CW    = wave_cap_pkg::STOP_CNT_W
) (
   input  wire logic          clk_i,         // 25 MHz clock
   input  wire logic          reset_i,       // Async reset, high
   input  wire logic          arm_i,         // Pulse: restart capture window
   input  wire logic [1:0]    above_hi_i,    // Hi comparator, [0] older 20 ns half
   input  wire logic [1:0]    above_lo_i,    // Lo comparator, [0] older 20 ns half
   input  wire logic          stop_i,        // External stop line level
   input  wire logic          stop_rise_i,   // 1: rising stop edge, 0: falling
   input  wire logic          cnt_mode_i,    // Stop counter in use
   input  wire logic [CW-1:0] cnt_preset_i,  // Gated clocks before stop
   input  wire logic          gclk_i,        // Gated clock pulse
   input  wire logic [3:0]    dly_sel_i,     // Requested delay steps
   input  wire logic          rd_start_i,    // Pulse: stream the frozen store
   input  wire logic          out_ready_i,   // Receiver ready
   output logic               out_valid_o,   // Sample word valid
   output logic [1:0]         out_data_o,    // Sample code
   output logic               capturing_o,   // Store being written
   output logic               frozen_o,      // Store frozen, readable
   output logic [3:0]         dly_tap_o      // Delay line tap select
);
   import wave_cap_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] STEP = AW'(SMP_PER_CLK);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [3:0]    DLY_MAX = 4'(DLY_MAX_STEPS);

   typedef struct packed {
      cap_state_e             st;
      logic [DEPTH-1:0][1:0]  mem;
      logic [AW-1:0]          wp;
      logic [AW-1:0]          rk;
      logic [CW-1:0]          cnt;
      logic                   stop_q;
      logic                   cap;
      logic                   frz;
      logic [3:0]             tap;
   } cap_s;

   cap_s       st_ff;
   cap_s       nxt_st;
   logic       stop_edge;
   logic       cnt_zero;
   logic       stop_now;
   logic       push;
   logic       push_rdy;
   logic [1:0] push_data;

   // -------------------------------------------------
   // Stop sources
   // -------------------------------------------------
   // stop edge in the direction set by stop_rise_i
   assign stop_edge = stop_rise_i ? (stop_i && !st_ff.stop_q) : (!stop_i && st_ff.stop_q);
   assign cnt_zero  = cnt_mode_i && gclk_i && (st_ff.cnt <= CW'(1));
   assign stop_now  = stop_edge || cnt_zero;
   assign push      = (st_ff.st == ST_DUMP);
   // oldest entry sits at the write pointer
   assign push_data = st_ff.mem[AW'(st_ff.wp + st_ff.rk)];

   // -------------------------------------------------
   // Next state
   // -------------------------------------------------
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.stop_q = stop_i;
      nxt_st.tap    = (dly_sel_i > DLY_MAX) ? DLY_MAX : dly_sel_i;
      case (st_ff.st)
         ST_CAPTURE: begin
            if (stop_now) begin
               nxt_st.st = ST_FROZEN;
            end else begin
               // two 20 ns samples per clock
               nxt_st.mem[st_ff.wp]          = classify(above_hi_i[0], above_lo_i[0]);
               nxt_st.mem[AW'(st_ff.wp + 1)] = classify(above_hi_i[1], above_lo_i[1]);
               nxt_st.wp = AW'(st_ff.wp + STEP);
               if (cnt_mode_i && gclk_i) begin
                  nxt_st.cnt = CW'(st_ff.cnt - CW'(1));
               end
            end
         end
         ST_FROZEN: begin
            if (rd_start_i) begin
               nxt_st.st = ST_DUMP;
               nxt_st.rk = '0;
            end
         end
         ST_DUMP: begin
            if (push_rdy) begin
               nxt_st.rk = AW'(st_ff.rk + 1);
               if (st_ff.rk == LAST) begin
                  nxt_st.st = ST_FROZEN;
               end
            end
         end
         default: begin
         end
      endcase
      // Arm overrides the state, write pointer and counter and restarts the window
      if (arm_i) begin
         nxt_st.st  = ST_CAPTURE;
         nxt_st.wp  = '0;
         nxt_st.cnt = cnt_preset_i;
      end
      nxt_st.cap = (nxt_st.st == ST_CAPTURE);
      nxt_st.frz = (nxt_st.st == ST_FROZEN) || (nxt_st.st == ST_DUMP);
   end

   // -------------------------------------------------
   // State register
   // -------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff     <= '0;
         st_ff.st  <= ST_IDLE;
         st_ff.mem <= {DEPTH{SMP_RST}};
         st_ff.tap <= DLY_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Readout buffer keeps words across receiver stalls
   skid_buf2 #(.W(2)) u_out_buf (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (push),
      .in_data_i   (push_data),
      .in_ready_o  (push_rdy),
      .out_valid_o (out_valid_o),
      .out_data_o  (out_data_o),
      .out_ready_i (out_ready_i)
   );

   assign capturing_o = st_ff.cap;
   assign frozen_o    = st_ff.frz;
   assign dly_tap_o   = st_ff.tap;

   // -------------------------------------------------
   // Assertions
   // -------------------------------------------------
   sequence s_stop_hit;
      st_ff.st == ST_CAPTURE && stop_edge && !arm_i;
   endsequence

   sequence s_cnt_hit;
      st_ff.st == ST_CAPTURE && cnt_mode_i && gclk_i && st_ff.cnt == CW'(1) && !arm_i;
   endsequence

   property p_stop_freeze;
      @(posedge clk_i) disable iff (reset_i)
      s_stop_hit |=> frozen_o && !capturing_o;
   endproperty
   a_stop_freeze: assert property (p_stop_freeze) else $error("stop edge did not freeze");

   property p_cnt_freeze;
      @(posedge clk_i) disable iff (reset_i)
      s_cnt_hit |=> st_ff.st == ST_FROZEN;
   endproperty
   a_cnt_freeze: assert property (p_cnt_freeze) else $error("counter zero did not freeze");

   property p_either_stop;
      @(posedge clk_i) disable iff (reset_i)
      (st_ff.st == ST_CAPTURE && !arm_i && !stop_edge && !cnt_zero) |=> capturing_o;
   endproperty
   a_either_stop: assert property (p_either_stop) else $error("capture ended without stop");

   property p_hold;
      @(posedge clk_i) disable iff (reset_i)
      (frozen_o && !arm_i) |=> $stable(st_ff.mem) && $stable(st_ff.wp);
   endproperty
   a_hold: assert property (p_hold) else $error("frozen store changed");

   property p_edge_out;
      @(posedge clk_i) disable iff (reset_i)
      s_stop_hit |=> st_ff.wp == $past(st_ff.wp);
   endproperty
   a_edge_out: assert property (p_edge_out) else $error("stop cycle was stored");

   property p_spacing;
      @(posedge clk_i) disable iff (reset_i)
      (st_ff.st == ST_CAPTURE && !stop_now && !arm_i) |=> st_ff.wp == AW'($past(st_ff.wp) + STEP);
   endproperty
   a_spacing: assert property (p_spacing) else $error("write step wrong");

   property p_code;
      @(posedge clk_i) disable iff (reset_i)
      out_valid_o |-> out_data_o != 2'h3;
   endproperty
   a_code: assert property (p_code) else $error("illegal sample code");

   // Both comparators above threshold must land in the store as high
   property p_store_code;
      @(posedge clk_i) disable iff (reset_i)
      (st_ff.st == ST_CAPTURE && !stop_now && !arm_i && above_hi_i[0] && above_lo_i[0])
         |=> st_ff.mem[$past(st_ff.wp)] == SMP_HIGH;
   endproperty
   a_store_code: assert property (p_store_code) else $error("high sample stored wrong");

   property p_oldest_first;
      @(posedge clk_i) disable iff (reset_i)
      (st_ff.st == ST_FROZEN && rd_start_i && !arm_i)
         |=> st_ff.rk == '0 ##0 push_data == st_ff.mem[st_ff.wp];
   endproperty
   a_oldest_first: assert property (p_oldest_first) else $error("readout not oldest first");

   property p_tap;
      @(posedge clk_i) disable iff (reset_i)
      1'b1 |=> (dly_tap_o <= DLY_MAX)
         && (dly_tap_o == $past(dly_sel_i) || $past(dly_sel_i) > DLY_MAX);
   endproperty
   a_tap: assert property (p_tap) else $error("delay tap wrong");

   property p_wrap;
      @(posedge clk_i) disable iff (reset_i)
      (st_ff.st == ST_CAPTURE && st_ff.wp == AW'(DEPTH - SMP_PER_CLK) && !stop_now && !arm_i)
         |=> st_ff.wp == '0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("store did not wrap");
endmodule

// ==== verif/probe_tip_model.sv ====
// Probe tip model: per-slot level codes to comparator pairs
`timescale 1ns/1ps
module probe_tip_model
   import wave_cap_pkg::*;
(
   input  wire logic [1:0] slot0_i,    // Older 20 ns slot code
   input  wire logic [1:0] slot1_i,    // Newer 20 ns slot code
   output logic [1:0]      above_hi_o, // High threshold comparator
   output logic [1:0]      above_lo_o  // Low threshold comparator
);
   // ----------------------------------------
   // Comparator front end
   // ----------------------------------------
   // levels held for whole slots, no fast edges
   // A floating tip rests between thresholds: low trips, high does not
   assign above_hi_o = {slot1_i == SMP_HIGH, slot0_i == SMP_HIGH};
   assign above_lo_o = {slot1_i != SMP_LOW, slot0_i != SMP_LOW};
endmodule

// ==== verif/probe_waveform_capture_tb.sv ====
// Testbench for the probe waveform capture block
`timescale 1ns/1ps
module probe_waveform_capture_tb;
   import wave_cap_pkg::*;
   logic clk_i = 0, reset_i = 1, arm_i = 0, stop_i = 0, stop_rise_i = 1, cnt_mode_i = 0;
   logic gclk_i = 0, rd_start_i = 0, out_ready_i = 1, out_valid_o, capturing_o, frozen_o;
   logic [15:0] cnt_preset_i = 16'h0;
   logic [3:0]  dly_sel_i = 4'h0, dly_tap_o;
   logic [1:0]  hi, lo, out_data_o, slot0 = 2'h0, slot1 = 2'h0;
   logic [1:0]  mem [32];
   logic [1:0]  got [$];
   int          wp = 0, err_total = 0, n_checks = 0;

   probe_tip_model tip (.slot0_i(slot0), .slot1_i(slot1), .above_hi_o(hi), .above_lo_o(lo));
   probe_wave_capture uut (.clk_i(clk_i), .reset_i(reset_i), .arm_i(arm_i), .above_hi_i(hi),
      .above_lo_i(lo), .stop_i(stop_i), .stop_rise_i(stop_rise_i), .cnt_mode_i(cnt_mode_i),
      .cnt_preset_i(cnt_preset_i), .gclk_i(gclk_i), .dly_sel_i(dly_sel_i),
      .rd_start_i(rd_start_i), .out_ready_i(out_ready_i), .out_valid_o(out_valid_o),
      .out_data_o(out_data_o), .capturing_o(capturing_o), .frozen_o(frozen_o),
      .dly_tap_o(dly_tap_o));

   // ----------------------------------------
   // Clock, word monitor, shared tasks
   // ----------------------------------------
   initial begin
      forever #20 clk_i = ~clk_i;
   end

   // Words are taken only at an edge with both valid and ready high
   always @(posedge clk_i) begin
      if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
         got.push_back(out_data_o);
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         err_total++;
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic arm();
      arm_i <= 1'b1;
      @(posedge clk_i);
      arm_i <= 1'b0;
      wp = 0;
      got.delete();
   endtask

   // One clock of probe history; keep says whether the block should store it
   task automatic step(input logic [1:0] a, b, input logic stp, g, keep);
      slot0 <= a;
      slot1 <= b;
      stop_i <= stp;
      gclk_i <= g;
      @(posedge clk_i);
      if (keep) begin
         mem[wp] = a;
         mem[(wp + 1) % 32] = b;
         wp = (wp + 2) % 32;
      end
   endtask

   // Run n stored clocks cycling through all three codes
   task automatic run(input int n, input logic stp, g);
      for (int k = 0; k < n; k++) begin
         step(2'((2 * k) % 3), 2'((k / 2) % 3), stp, g, 1'b1);
      end
      check("capturing", {7'h0, capturing_o}, 8'h1);
   endtask

   // Freeze step with a code pair that must not be stored, then confirm freeze
   task automatic stop_at(input logic stp, g);
      step(SMP_HIGH, SMP_HIGH, stp, g, 1'b0);
      step(SMP_LOW, SMP_LOW, ~stp, 1'b1, 1'b0);
      check("frozen", {7'h0, frozen_o}, 8'h1);
      check("capturing off", {7'h0, capturing_o}, 8'h0);
   endtask

   // store read only after capture has frozen
   task automatic readout(input string name);
      check("early words", 8'(got.size()), 8'h0);
      rd_start_i <= 1'b1;
      @(posedge clk_i);
      rd_start_i <= 1'b0;
      for (int c = 0; c < 300 && got.size() < 32; c++) begin
         out_ready_i <= (c % 3 != 2);
         @(posedge clk_i);
      end
      out_ready_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      check("word count", 8'(got.size()), 8'h20);
      for (int i = 0; i < 32 && i < got.size(); i++) begin
         check("word", {6'h0, got[i]}, {6'h0, mem[(wp + i) % 32]});
      end
      check("frozen after", {7'h0, frozen_o}, 8'h1);
      $display("done %s", name);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_fill();
      check("idle valid", {7'h0, out_valid_o}, 8'h0);
      check("delay reset", {4'h0, dly_tap_o}, {4'h0, DLY_RST});
      foreach (mem[i]) mem[i] = SMP_RST;
      arm();
      run(2, 1'b0, 1'b0);
      stop_at(1'b1, 1'b0);
      readout("reset fill");
   endtask

   task automatic t_ext_stop();
      stop_i <= 1'b0;
      arm();
      rd_start_i <= 1'b1;
      run(1, 1'b0, 1'b0);
      rd_start_i <= 1'b0;
      run(18, 1'b0, 1'b0);
      stop_at(1'b1, 1'b0);
      readout("external rising stop");
   endtask

   task automatic t_cnt_stop();
      cnt_mode_i <= 1'b1;
      cnt_preset_i <= 16'h14;
      stop_i <= 1'b0;
      arm();
      run(19, 1'b0, 1'b1);
      stop_at(1'b0, 1'b1);
      readout("counter stop");
   endtask

   task automatic t_first_wins();
      stop_rise_i <= 1'b0;
      cnt_preset_i <= 16'h28;
      stop_i <= 1'b1;
      arm();
      run(17, 1'b1, 1'b1);
      stop_at(1'b0, 1'b1);
      readout("falling stop beats counter");
   endtask

   task automatic t_delay();
      for (int s = 0; s < 16; s++) begin
         dly_sel_i <= 4'(s);
         @(posedge clk_i);
         @(posedge clk_i);
         check("delay tap", {4'h0, dly_tap_o}, 8'(s > DLY_MAX_STEPS ? DLY_MAX_STEPS : s));
      end
      $display("done delay select");
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      t_reset_fill();
      t_ext_stop();
      t_cnt_stop();
      t_first_wins();
      t_delay();
      end_sim();
   end

   // Watchdog sized well above the roughly 330 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      end_sim();
   end
endmodule
